// ---- rtl/nfb_pkg.sv ----
// Shared constants, types and helpers for the NAND flash bus host controller.
package nfb_pkg;

  // ----------------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int T_WP_NS = 15;
  localparam int T_WH_NS = 10;
  localparam int T_CLS_NS = 15;
  localparam int T_REA_NS = 25;
  localparam int T_WB_NS = 100;
  localparam int SYNC_STAGES = 2;

  // Converts a least time in ns into whole clock cycles, at least one.
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction : ns2cyc

  localparam logic [3:0] C_SETUP = 4'(ns2cyc(T_CLS_NS));
  localparam logic [3:0] C_WP = 4'(ns2cyc(T_WP_NS));
  localparam logic [3:0] C_WH = 4'(ns2cyc(T_WH_NS));
  localparam logic [3:0] C_REA = 4'(ns2cyc(T_REA_NS) + SYNC_STAGES);
  localparam logic [3:0] C_WB = 4'(ns2cyc(T_WB_NS));

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int PAGE_BYTES = 2112;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCKS = 16384;
  localparam int COL_W = 12;
  localparam int PAGE_W = 6;
  localparam int BLOCK_W = 14;
  localparam int ROW_W = 19;
  localparam int SEL_BIT = 13;

  // ----------------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG2 = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {K_CMD = 2'h0, K_ADDR = 2'h1, K_WR = 2'h2, K_RD = 2'h3} nfb_kind_t;

  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROG = 3'h1, OP_ERASE = 3'h2,
    OP_ID = 3'h3, OP_RESET = 3'h4, OP_STATUS = 3'h5
  } nfb_op_t;

  typedef struct packed {
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic has_cmd2;
    logic has_addr;
    logic [2:0] addr_first;
    logic [2:0] addr_last;
    logic din;
    logic wait_rdy;
    logic stat_after;
    logic dout;
    logic stat_out;
    logic protect;
    logic [11:0] nout;
  } nfb_opinfo_t;

  // Sequence of one operation; nout of zero means the user length.
  function automatic nfb_opinfo_t op_info(input nfb_op_t op);
    nfb_opinfo_t f;
    f = '0;
    unique case (op)
      OP_READ: f = '{CMD_READ1, CMD_READ2, 1'b1, 1'b1, 3'h0, 3'h4, 1'b0, 1'b1,
                     1'b0, 1'b1, 1'b0, 1'b0, 12'h000};
      OP_PROG: f = '{CMD_PROG1, CMD_PROG2, 1'b1, 1'b1, 3'h0, 3'h4, 1'b1, 1'b1,
                     1'b1, 1'b1, 1'b0, 1'b1, 12'h001};
      OP_ERASE: f = '{CMD_ERASE1, CMD_ERASE2, 1'b1, 1'b1, 3'h2, 3'h4, 1'b0, 1'b1,
                      1'b1, 1'b1, 1'b0, 1'b1, 12'h001};
      OP_ID: f = '{CMD_ID, 8'h00, 1'b0, 1'b1, 3'h0, 3'h0, 1'b0, 1'b0,
                   1'b0, 1'b1, 1'b0, 1'b0, 12'h002};
      OP_RESET: f = '{CMD_RESET, 8'h00, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0, 1'b1,
                      1'b0, 1'b0, 1'b0, 1'b0, 12'h000};
      OP_STATUS: f = '{CMD_STATUS, 8'h00, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0, 1'b0,
                       1'b0, 1'b1, 1'b1, 1'b0, 12'h001};
      default: f = '0;
    endcase
    return f;
  endfunction : op_info

  // Byte of the five address cycles: two column bytes, three row bytes.
  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [COL_W-1:0] col,
                                           input logic [ROW_W-1:0] row);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      3'h0: b = col[7:0];
      3'h1: b = {4'h0, col[11:8]};
      3'h2: b = row[7:0];
      3'h3: b = row[15:8];
      default: b = {5'h00, row[18:16]};
    endcase
    return b;
  endfunction : addr_byte

endpackage : nfb_pkg

// ---- rtl/nfb_bus_cycle.sv ----
// One strobed bus cycle on the flash pins: command, address, write or read byte.
`timescale 1ns/1ps
module nfb_bus_cycle import nfb_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire nfb_kind_t i_kind,
  input wire logic [7:0] i_byte,
  input wire logic [7:0] i_io_sync,
  output logic o_done,
  output logic [7:0] o_rbyte,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_read_strobe_n,
  output logic [7:0] o_io_out,
  output logic o_io_oe
);

  typedef enum logic [1:0] {B_IDLE = 2'h0, B_SETUP = 2'h1, B_LOW = 2'h3, B_HIGH = 2'h2} nfb_bst_t;

  nfb_bst_t st_q, st_d;
  nfb_kind_t kind_q, kind_d;
  logic [3:0] cnt_q, cnt_d;
  logic done_d, cle_d, ale_d, we_n_d, re_n_d, io_oe_d;
  logic [7:0] rbyte_d, io_out_d;

  // ----------------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------------

  // Sets up the latch strobes and data, pulses a strobe low, then holds.
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    cle_d = o_cle;
    ale_d = o_ale;
    we_n_d = o_we_n;
    re_n_d = o_read_strobe_n;
    io_oe_d = o_io_oe;
    io_out_d = o_io_out;
    rbyte_d = o_rbyte;
    unique case (st_q)
      B_IDLE: begin
        if (i_start) begin
          kind_d = i_kind;
          cle_d = (i_kind == K_CMD);
          ale_d = (i_kind == K_ADDR);
          io_oe_d = (i_kind != K_RD);
          io_out_d = i_byte;
          cnt_d = C_SETUP - 4'h1;
          st_d = B_SETUP;
        end
      end
      B_SETUP: begin
        if (cnt_q == 4'h0) begin
          st_d = B_LOW;
          if (kind_q == K_RD) begin
            re_n_d = 1'b0;
            cnt_d = C_REA - 4'h1;
          end else begin
            we_n_d = 1'b0;
            cnt_d = C_WP - 4'h1;
          end
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      B_LOW: begin
        if (cnt_q == 4'h0) begin
          we_n_d = 1'b1;
          re_n_d = 1'b1;
          if (kind_q == K_RD) begin
            rbyte_d = i_io_sync;
          end
          cnt_d = C_WH - 4'h1;
          st_d = B_HIGH;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      B_HIGH: begin
        if (cnt_q == 4'h0) begin
          cle_d = 1'b0;
          ale_d = 1'b0;
          io_oe_d = 1'b0;
          done_d = 1'b1;
          st_d = B_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
    endcase
  end

  // Registers the cycle state and every pin.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st_q <= B_IDLE;
      kind_q <= K_CMD;
      cnt_q <= 4'h0;
      o_done <= 1'b0;
      o_rbyte <= 8'h00;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_io_out <= 8'h00;
      o_io_oe <= 1'b0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      o_done <= done_d;
      o_rbyte <= rbyte_d;
      o_cle <= cle_d;
      o_ale <= ale_d;
      o_we_n <= we_n_d;
      o_read_strobe_n <= re_n_d;
      o_io_out <= io_out_d;
      o_io_oe <= io_oe_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  chk_we_low_width: assert property ($fell(o_we_n) |-> !o_we_n[*2] ##1 o_we_n)
    else $error("Write strobe low width wrong.");
  chk_latch_stable: assert property (!o_we_n |=> $stable(o_cle) && $stable(o_ale))
    else $error("Latch strobe moved around write strobe.");
  chk_latch_excl: assert property (!(o_cle && o_ale))
    else $error("Both latch strobes high.");
  chk_read_release: assert property (!o_read_strobe_n |-> !o_io_oe)
    else $error("Host drives bus during read.");
  chk_re_width: assert property ($fell(o_read_strobe_n) |-> !o_read_strobe_n[*5] ##1
                                  (o_read_strobe_n && $changed(o_rbyte) || o_read_strobe_n))
    else $error("Read strobe low width wrong.");

endmodule : nfb_bus_cycle

// ---- rtl/nfb_host.sv ----
// Host controller that drives a NAND flash over its multiplexed pins.
`timescale 1ns/1ps

module nfb_host import nfb_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire nfb_op_t i_cmd_op,
  input wire logic [BLOCK_W-1:0] i_block,
  input wire logic [PAGE_W-1:0] i_page,
  input wire logic [COL_W-1:0] i_col,
  input wire logic [11:0] i_len,
  input wire logic i_boot_read_en,
  input wire logic [7:0] i_wdata,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [7:0] o_status,
  output logic o_cmd_ready,
  output logic o_done,
  input wire logic [7:0] i_io_in,
  input wire logic i_ready_busy,
  output logic [7:0] o_io_out,
  output logic o_io_oe,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_read_strobe_n,
  output logic o_device_select_first_n,
  output logic o_device_select_second_n,
  output logic o_wp_n,
  output logic o_pre
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CMD1 = 4'h1, S_ADDR = 4'h3, S_DIN = 4'h2, S_CMD2 = 4'h6,
    S_WB = 4'h7, S_RDY = 4'h5, S_STCMD = 4'h4, S_DOUT = 4'hC, S_DONE = 4'hD
  } nfb_st_t;

  nfb_st_t st_q, st_d;
  nfb_opinfo_t info_q, info_d;
  logic [COL_W-1:0] col_q, col_d;
  logic [ROW_W-1:0] row_q, row_d;
  logic [11:0] len_q, len_d, cnt_q, cnt_d, nout;
  logic iss_q, iss_d, wait_q, wait_d, stat_q, stat_d;
  logic start_q, start_d;
  nfb_kind_t kind_q, kind_d;
  logic [7:0] byte_q, byte_d, rdata_d, status_d;
  logic wready_d, rvalid_d, done_d, sel1_d, sel2_d, wp_n_d, accept, free;
  logic [7:0] io_s1_q, io_s2_q;
  logic rb_s1_q, rb_s2_q;
  logic cyc_done;
  logic [7:0] cyc_rbyte;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Next phase after the first command, the address bytes or the data bytes.
  function automatic nfb_st_t after(input nfb_opinfo_t f, input logic [1:0] from);
    nfb_st_t s;
    if (from < 2'h1 && f.has_addr) s = S_ADDR;
    else if (from < 2'h2 && f.din) s = S_DIN;
    else if (f.has_cmd2) s = S_CMD2;
    else if (f.wait_rdy) s = S_WB;
    else if (f.dout) s = S_DOUT;
    else s = S_DONE;
    return s;
  endfunction : after

  // Counter value on entry to a phase.
  function automatic logic [11:0] entry_cnt(input nfb_st_t s, input nfb_opinfo_t f);
    logic [11:0] c;
    c = 12'h000;
    if (s == S_ADDR) c = {9'h000, f.addr_first};
    else if (s == S_WB) c = {8'h00, C_WB} - 12'h001;
    return c;
  endfunction : entry_cnt

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------

  // Brings the bus and the shared busy line into the clock domain.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      io_s1_q <= i_io_in;
      io_s2_q <= io_s1_q;
      rb_s1_q <= i_ready_busy;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------------
  assign free = !wait_q && !start_q;
  assign accept = i_wvalid && o_wready;
  assign nout = (info_q.nout == 12'h000) ? len_q : info_q.nout;

  // Walks each operation through its command, address, data and wait phases.
  always_comb begin
    st_d = st_q;
    info_d = info_q;
    col_d = col_q;
    row_d = row_q;
    len_d = len_q;
    cnt_d = cnt_q;
    iss_d = iss_q;
    stat_d = stat_q;
    start_d = 1'b0;
    kind_d = kind_q;
    byte_d = byte_q;
    rdata_d = o_rdata;
    status_d = o_status;
    rvalid_d = 1'b0;
    done_d = 1'b0;
    sel1_d = o_device_select_first_n;
    sel2_d = o_device_select_second_n;
    wp_n_d = o_wp_n;
    unique case (st_q)
      S_IDLE: begin
        if (i_cmd_valid) begin
          info_d = op_info(i_cmd_op);
          col_d = (i_cmd_op == OP_ID) ? '0 : i_col;
          row_d = {i_block[SEL_BIT-1:0], i_page};
          len_d = i_len;
          sel1_d = i_block[SEL_BIT];
          sel2_d = !i_block[SEL_BIT];
          wp_n_d = info_d.protect;
          stat_d = info_d.stat_out;
          iss_d = 1'b0;
          st_d = S_CMD1;
        end
      end
      S_CMD1, S_CMD2, S_STCMD: begin
        if (free && !iss_q) begin
          start_d = 1'b1;
          kind_d = K_CMD;
          byte_d = (st_q == S_CMD1) ? info_q.cmd1 : (st_q == S_CMD2) ? info_q.cmd2 : CMD_STATUS;
          iss_d = 1'b1;
        end else if (free) begin
          iss_d = 1'b0;
          if (st_q == S_CMD1) st_d = after(info_q, 2'h0);
          else if (st_q == S_CMD2) st_d = S_WB;
          else begin
            st_d = S_DOUT;
            stat_d = 1'b1;
          end
          cnt_d = entry_cnt(st_d, info_q);
        end
      end
      S_ADDR: begin
        if (free && !iss_q) begin
          start_d = 1'b1;
          kind_d = K_ADDR;
          byte_d = addr_byte(cnt_q[2:0], col_q, row_q);
          iss_d = 1'b1;
        end else if (free) begin
          iss_d = 1'b0;
          if (cnt_q[2:0] == info_q.addr_last) begin
            st_d = after(info_q, 2'h1);
            cnt_d = entry_cnt(st_d, info_q);
          end else begin
            cnt_d = cnt_q + 12'h001;
          end
        end
      end
      S_DIN: begin
        if (accept) begin
          start_d = 1'b1;
          kind_d = K_WR;
          byte_d = i_wdata;
          iss_d = 1'b1;
        end else if (free && iss_q) begin
          iss_d = 1'b0;
          if (cnt_q + 12'h001 == len_q) begin
            st_d = after(info_q, 2'h2);
            cnt_d = entry_cnt(st_d, info_q);
          end else begin
            cnt_d = cnt_q + 12'h001;
          end
        end
      end
      S_WB: begin
        if (cnt_q == 12'h000) st_d = S_RDY;
        else cnt_d = cnt_q - 12'h001;
      end
      S_RDY: begin
        if (rb_s2_q) begin
          st_d = info_q.stat_after ? S_STCMD : (info_q.dout ? S_DOUT : S_DONE);
          cnt_d = 12'h000;
        end
      end
      S_DOUT: begin
        if (free && !iss_q) begin
          start_d = 1'b1;
          kind_d = K_RD;
          iss_d = 1'b1;
        end else if (free) begin
          iss_d = 1'b0;
          if (stat_q) status_d = cyc_rbyte;
          else begin
            rdata_d = cyc_rbyte;
            rvalid_d = 1'b1;
          end
          if (cnt_q + 12'h001 == nout) st_d = S_DONE;
          else cnt_d = cnt_q + 12'h001;
        end
      end
      S_DONE: begin
        done_d = 1'b1;
        sel1_d = 1'b1;
        sel2_d = 1'b1;
        wp_n_d = 1'b0;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    wait_d = start_d || (wait_q && !cyc_done);
    wready_d = (st_q == S_DIN) && !wait_q && !start_q && !iss_q && !accept && (st_d == S_DIN);
  end

  // Registers the sequencer; write protect starts low across power-up.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st_q <= S_IDLE;
      info_q <= '0;
      col_q <= '0;
      row_q <= '0;
      len_q <= 12'h000;
      cnt_q <= 12'h000;
      iss_q <= 1'b0;
      wait_q <= 1'b0;
      stat_q <= 1'b0;
      start_q <= 1'b0;
      kind_q <= K_CMD;
      byte_q <= 8'h00;
      o_wready <= 1'b0;
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
      o_status <= 8'h00;
      o_cmd_ready <= 1'b0;
      o_done <= 1'b0;
      o_device_select_first_n <= 1'b1;
      o_device_select_second_n <= 1'b1;
      o_wp_n <= 1'b0;
      o_pre <= 1'b0;
    end else begin
      st_q <= st_d;
      info_q <= info_d;
      col_q <= col_d;
      row_q <= row_d;
      len_q <= len_d;
      cnt_q <= cnt_d;
      iss_q <= iss_d;
      wait_q <= wait_d;
      stat_q <= stat_d;
      start_q <= start_d;
      kind_q <= kind_d;
      byte_q <= byte_d;
      o_wready <= wready_d;
      o_rdata <= rdata_d;
      o_rvalid <= rvalid_d;
      o_status <= status_d;
      o_cmd_ready <= (st_d == S_IDLE);
      o_done <= done_d;
      o_device_select_first_n <= sel1_d;
      o_device_select_second_n <= sel2_d;
      o_wp_n <= wp_n_d;
      o_pre <= i_boot_read_en;
    end
  end

  // ----------------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------------
  nfb_bus_cycle u_cycle (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_start(start_q),
    .i_kind(kind_q),
    .i_byte(byte_q),
    .i_io_sync(io_s2_q),
    .o_done(cyc_done),
    .o_rbyte(cyc_rbyte),
    .o_cle(o_cle),
    .o_ale(o_ale),
    .o_we_n(o_we_n),
    .o_read_strobe_n(o_read_strobe_n),
    .o_io_out(o_io_out),
    .o_io_oe(o_io_oe)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  chk_wp_idle_low: assert property (st_q == S_IDLE |-> !o_wp_n)
    else $error("Write protect released while idle.");
  chk_protect_read_ops: assert property (st_q == S_CMD1 && !info_q.protect |-> !o_wp_n)
    else $error("Write protect released for non-modify op.");
  chk_one_select: assert property (!(!o_device_select_first_n && !o_device_select_second_n))
    else $error("Both selects asserted.");
  chk_busy_hold: assert property (st_q == S_RDY && !rb_s2_q |=> st_q == S_RDY)
    else $error("Left busy wait while device busy.");
  chk_wb_length: assert property ($rose(st_q == S_WB) |-> (st_q == S_WB)[*8] ##1
                                  (st_q == S_WB)[*2] ##1 (st_q == S_RDY))
    else $error("Busy settle delay is not ten cycles.");

endmodule : nfb_host

// ---- tb/nfb_flash_model.sv ----
// Behavioural NAND flash device that answers the host controller pins.
`timescale 1ns/1ps
module nfb_flash_model (
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_read_strobe_n,
  input wire logic i_device_select_first_n,
  input wire logic i_device_select_second_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_io,
  input wire logic i_io_oe,
  output logic [7:0] o_io,
  output logic o_rb_low,
  output int o_faults
);
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary maker code.
  localparam logic [7:0] DEVID = 8'hC3; // Arbitrary device code.
  logic [7:0] mem [logic [31:0]];
  logic [7:0] pbuf [logic [31:0]];
  logic [7:0] a [0:4];
  logic [7:0] dq = 8'h00;
  logic [7:0] last = 8'h00;
  logic busy = 1'b0;
  logic drv = 1'b0;
  logic sel = 1'b0;
  logic idx = 1'b0;
  logic [11:0] col = 12'h000;
  logic [18:0] row = 19'h00000;
  int n = 0;
  int mode = 0;
  wire cs = !(i_device_select_first_n && i_device_select_second_n);

  // Busy pulls the shared line low; a released bus shows the inverse of its last byte.
  assign o_rb_low = busy;
  assign o_io = drv ? dq : ~last;
  initial o_faults = 0;

  // Holds the device busy for a fixed time without blocking the pin watchers.
  task automatic go(input int t);
    fork
      begin
        busy = 1'b1;
        #(t) busy = 1'b0;
      end
    join_none
  endtask : go

  // Decodes one latched command byte.
  task automatic cmd(input logic [7:0] c);
    sel = i_device_select_first_n;
    case (c)
      8'h00: begin n = 0; mode = 0; end
      8'h30: begin mode = 1; go(300); end
      8'h90: begin n = 0; mode = 2; idx = 1'b0; end
      8'h80: begin n = 0; mode = 4; pbuf.delete(); end
      8'h10: begin
        if (i_wp_n) foreach (pbuf[k]) mem[k] = pbuf[k];
        mode = 3;
        go(2000);
      end
      8'h60: begin n = 2; mode = 0; end
      // Erase clears the whole model array, a simplification.
      8'hD0: begin if (i_wp_n) mem.delete(); mode = 3; go(5000); end
      8'h70: mode = 3;
      8'hFF: begin mode = 0; go(500); end
      default: o_faults++;
    endcase
  endtask : cmd

  // Latches commands, addresses and data on the write strobe rise.
  always @(posedge i_we_n) begin
    if (cs) begin
      if (!i_io_oe || (i_cle && i_ale)) o_faults++;
      if (busy && !(i_cle && (i_io == 8'h70 || i_io == 8'hFF))) o_faults++;
      if (i_cle) cmd(i_io);
      else if (i_ale) begin
        a[n % 5] = i_io;
        n++;
        col = {a[1][3:0], a[0]};
        row = {a[4][2:0], a[3], a[2]};
      end else if (mode == 4) begin
        pbuf[{sel, row, col}] = i_io;
        col++;
      end
    end
  end

  // Drives the next byte shortly after each read strobe fall.
  always @(negedge i_read_strobe_n) begin
    if (cs) begin
      if (busy || i_io_oe) o_faults++;
      case (mode)
        1: begin
          dq = mem.exists({sel, row, col}) ? mem[{sel, row, col}] : col[7:0] ^ row[7:0];
          col++;
        end
        2: begin dq = idx ? DEVID : MAKER; idx = 1'b1; end
        default: dq = {i_wp_n, ~busy, 6'h00};
      endcase
      #20 drv = 1'b1;
      last = dq;
    end
  end

  // Releases the bus a short hold after the read strobe rises.
  always @(posedge i_read_strobe_n) #5 drv = 1'b0;
endmodule : nfb_flash_model

// ---- tb/nfb_host_tb.sv ----
// Self-checking bench for the NAND flash host controller.
`timescale 1ns/1ps
module nfb_host_tb import nfb_pkg::*; ();
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_cmd_valid = 1'b0;
  nfb_op_t i_cmd_op = OP_READ;
  logic [BLOCK_W-1:0] i_block = '0;
  logic [PAGE_W-1:0] i_page = '0;
  logic [COL_W-1:0] i_col = '0;
  logic [11:0] i_len = 12'h001;
  logic i_boot_read_en = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wvalid = 1'b0;
  logic o_wready, o_rvalid, o_cmd_ready, o_done, o_io_oe, o_cle, o_ale, o_we_n;
  logic o_read_strobe_n, o_sel1_n, o_sel2_n, o_wp_n, o_pre, rb_low;
  logic [7:0] o_rdata, o_status, o_io_out, dev_io;
  wire [7:0] io_bus = o_io_oe ? o_io_out : dev_io;
  int faults;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] rq [$];
  logic [7:0] wq [$];

  nfb_host i_nfb_host (.i_mclk(i_mclk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_block(i_block), .i_page(i_page), .i_col(i_col), .i_len(i_len),
    .i_boot_read_en(i_boot_read_en), .i_wdata(i_wdata), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_status(o_status),
    .o_cmd_ready(o_cmd_ready), .o_done(o_done), .i_io_in(io_bus), .i_ready_busy(~rb_low),
    .o_io_out(o_io_out), .o_io_oe(o_io_oe), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
    .o_read_strobe_n(o_read_strobe_n), .o_device_select_first_n(o_sel1_n),
    .o_device_select_second_n(o_sel2_n), .o_wp_n(o_wp_n), .o_pre(o_pre));

  nfb_flash_model i_nfb_flash_model (.i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_read_strobe_n(o_read_strobe_n), .i_device_select_first_n(o_sel1_n),
    .i_device_select_second_n(o_sel2_n), .i_wp_n(o_wp_n), .i_io(o_io_out),
    .i_io_oe(o_io_oe), .o_io(dev_io), .o_rb_low(rb_low), .o_faults(faults));

  // Free-running system clock.
  always #5 i_mclk = ~i_mclk;

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // Compares one byte result.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected byte at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk8

  // Compares one flag result.
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected flag at %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk1

  // Issues one operation, feeds the write queue and gathers read bytes until done.
  task automatic run_op(input nfb_op_t op, input logic [13:0] b, input logic [5:0] p,
                        input logic [11:0] c, input logic [11:0] l);
    int n;
    int k;
    logic tk;
    k = 0;
    rq.delete();
    #1;
    i_cmd_op = op;
    i_block = b;
    i_page = p;
    i_col = c;
    i_len = l;
    i_cmd_valid = 1'b1;
    for (n = 0; n < 20000; n++) begin
      @(posedge i_mclk);
      tk = (o_cmd_ready === 1'b1);
      if (o_wready === 1'b1 && i_wvalid) k++;
      if (o_rvalid === 1'b1) rq.push_back(o_rdata);
      if (o_done === 1'b1) break;
      #1;
      if (tk) i_cmd_valid = 1'b0;
      i_wvalid = (k < wq.size());
      if (k < wq.size()) i_wdata = wq[k];
    end
    if (n == 20000) begin
      miscompares++;
      $display("unexpected timeout at %0t: operation never finished", $time);
      conclude();
    end
  endtask : run_op

  // Identification read returns maker then device code.
  task automatic t_id();
    run_op(OP_ID, 14'h0000, 6'h00, 12'h000, 12'h001);
    chk8(8'(rq.size()), 8'h02);
    chk8(rq[0], i_nfb_flash_model.MAKER);
    chk8(rq[1], i_nfb_flash_model.DEVID);
  endtask : t_id

  // Programs the last bytes of a page on the second select, reads them back and
  // reads the same row on the first select, which must stay untouched.
  task automatic t_prog_read();
    int i;
    logic [7:0] pat [$];
    wq = '{8'h11, 8'h22, 8'hA5, 8'h3C};
    pat = wq;
    run_op(OP_PROG, 14'h2005, 6'h3F, 12'h83C, 12'h004);
    wq.delete();
    chk8(o_status, 8'hC0);
    run_op(OP_READ, 14'h2005, 6'h3F, 12'h83C, 12'h004);
    chk8(8'(rq.size()), 8'h04);
    for (i = 0; i < 4; i++) chk8(rq[i], pat[i]);
    run_op(OP_READ, 14'h0005, 6'h3F, 12'h83C, 12'h004);
    chk8(8'(rq.size()), 8'h04);
    for (i = 0; i < 4; i++) chk8(rq[i], 8'(12'h83C + i) ^ 8'h7F);
  endtask : t_prog_read

  // Resets the device, reads the idle status, erases the programmed block and reads it blank.
  task automatic t_erase_status();
    run_op(OP_RESET, 14'h0000, 6'h00, 12'h000, 12'h001);
    chk1(o_wp_n, 1'b0);
    run_op(OP_STATUS, 14'h0000, 6'h00, 12'h000, 12'h001);
    chk8(o_status, 8'h40);
    run_op(OP_ERASE, 14'h2005, 6'h3F, 12'h000, 12'h001);
    chk8(o_status, 8'hC0);
    run_op(OP_READ, 14'h2005, 6'h3F, 12'h83C, 12'h001);
    chk8(rq[0], 8'h3C ^ 8'h7F);
  endtask : t_erase_status

  // Main sequence.
  initial begin
    repeat (3) @(posedge i_mclk);
    #1 chk1(o_wp_n, 1'b0);
    i_reset = 1'b0;
    i_boot_read_en = 1'b1;
    repeat (2) @(posedge i_mclk);
    #1 chk1(o_pre, 1'b1);
    t_id();
    t_prog_read();
    t_erase_status();
    chk8(8'(faults), 8'h00);
    conclude();
  end
endmodule : nfb_host_tb
